// ===== core/fsr_top.sv
// Flash status reporting block: command word decode, lock checks,
// non-volatile bit store and the read-only status word, on AHB-Lite.
// Assumes a single AHB-Lite master on hclk; the flash array itself
// is outside and each operation takes a fixed number of cycles.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_params.svh"

module fsr_top
  import fsr_pkg::*;
#(
  parameter int ADDR_W       = 32,
  parameter int REGIONS      = 16,
  parameter int REGION_SHIFT = 6,
  parameter int BUSY_CYCLES  = 16,
  parameter bit SECOND_PLANE = 1'b0
) (
  // Clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Interrupt
  output logic                   irq
);

  fsr_state_t s;
  fsr_state_t next_s;

  // Region that holds a given page
  function automatic logic [3:0] region_of(input logic [9:0] page);
    logic [9:0] shifted;
    shifted = page >> REGION_SHIFT;
    return shifted[3:0];
  endfunction

  // Flags present: the low 8 when REGIONS is 8 or fewer, otherwise all 16
  function automatic logic [15:0] region_mask();
    logic [15:0] m;
    m = 16'hFFFF;
    if (REGIONS <= 8) begin
      m = 16'h00FF;
    end
    return m;
  endfunction

  // Op codes this instance implements
  function automatic logic op_known(input logic [3:0] op);
    logic k;
    case (op)
      `FSR_OP_WRITE_PAGE,
      `FSR_OP_LOCK,
      `FSR_OP_WRITE_LOCK,
      `FSR_OP_UNLOCK,
      `FSR_OP_ERASE_ALL: k = 1'b1;
      `FSR_OP_SET_USER,
      `FSR_OP_CLR_USER,
      `FSR_OP_SET_SECURE: k = !SECOND_PLANE;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  logic [31:0] status_word;
  logic        ap_take;
  logic        ap_mapped;
  logic        cmd_write;
  logic        stat_read;
  logic [15:0] live_locks;

  // Stall the master while the block is frozen, so no beat is lost
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;
  assign irq       = |(s.irq_status & s.irq_mask);

  assign ap_take   = hsel && hready && htrans[1];
  assign ap_mapped = (haddr[ADDR_W-1:4] == '0);
  assign cmd_write = s.dp_valid && s.dp_write && (s.dp_off == `FSR_OFF_CMD);
  assign stat_read = ap_take && ap_mapped && !hwrite && (haddr[3:0] == `FSR_OFF_STATUS);
  assign live_locks = s.locks & region_mask();

  always_comb begin
    status_word = `FSR_RST_WORD;
    status_word[`FSR_BIT_IDLE]   = (s.phase == FSR_READY);
    status_word[`FSR_BIT_LOCKV]  = s.lock_viol;
    status_word[`FSR_BIT_BADCMD] = s.bad_cmd;
    if (!SECOND_PLANE) begin
      status_word[`FSR_BIT_SECURE] = s.security;
      status_word[`FSR_USER_HI:`FSR_USER_LO] = s.user_nvm;
    end
    status_word[`FSR_LOCKS_HI:`FSR_LOCKS_LO] = live_locks;
  end

  always_comb begin
    logic [3:0] opc;
    logic [7:0] key;
    logic [9:0] page;
    logic [3:0] rgn;
    logic       set_lockv;
    logic       set_bad;
    logic       set_done;
    logic [2:0] ev;
    logic [15:0] rmask;

    opc       = hwdata[`FSR_OPC_HI:`FSR_OPC_LO];
    key       = hwdata[`FSR_KEY_HI:`FSR_KEY_LO];
    page      = hwdata[`FSR_PAGE_HI:`FSR_PAGE_LO];
    rgn       = region_of(page);
    set_lockv = 1'b0;
    set_bad   = 1'b0;
    set_done  = 1'b0;
    ev        = `FSR_RST_EV;
    rmask     = region_mask();
    next_s    = s;

    // Address phase capture; read data is ready for the data phase
    next_s.dp_valid = ap_take;
    next_s.dp_write = hwrite;
    next_s.dp_off   = ap_mapped ? haddr[3:0] : `FSR_OFF_CMD;
    if (ap_take && !ap_mapped) begin
      next_s.dp_valid = 1'b0;
    end
    if (ap_take && !hwrite) begin
      if (!ap_mapped) begin
        next_s.rdata = `FSR_RST_WORD;
      end else if (haddr[3:0] == `FSR_OFF_STATUS) begin
        next_s.rdata = status_word;
      end else if (haddr[3:0] == `FSR_OFF_IRQ_STAT) begin
        next_s.rdata = {29'h0, s.irq_status};
      end else if (haddr[3:0] == `FSR_OFF_IRQ_MASK) begin
        next_s.rdata = {29'h0, s.irq_mask};
      end else begin
        next_s.rdata = `FSR_RST_WORD;
      end
    end

    // Command word: key first, then op code legality and lock checks
    if (cmd_write) begin
      if (key != `FSR_KEY) begin
        set_bad = 1'b1;
      end else if (opc == `FSR_OP_NONE) begin
        set_bad = 1'b0;
      end else if (!op_known(opc)) begin
        set_bad = 1'b1;
      end else if (s.phase == FSR_READY) begin
        if ((opc == `FSR_OP_WRITE_PAGE || opc == `FSR_OP_WRITE_LOCK) && live_locks[rgn]) begin
          set_lockv = 1'b1;
        end else if (opc == `FSR_OP_ERASE_ALL && (|live_locks)) begin
          set_lockv = 1'b0; // Erase of a partly locked array is cancelled
        end else begin
          next_s.phase = FSR_BUSY;
          next_s.count = 16'(BUSY_CYCLES - 1);
          next_s.op    = opc;
          next_s.page  = page;
        end
      end
    end

    // Running operation; its effect lands on the last busy cycle
    if (s.phase == FSR_BUSY) begin
      if (s.count == 16'h0000) begin
        next_s.phase = FSR_READY;
        set_done = 1'b1;
        case (s.op)
          `FSR_OP_LOCK,
          `FSR_OP_WRITE_LOCK: next_s.locks[region_of(s.page)] = rmask[region_of(s.page)];
          `FSR_OP_UNLOCK:     next_s.locks[region_of(s.page)] = 1'b0;
          `FSR_OP_SET_USER:   next_s.user_nvm[s.page[0]] = 1'b1;
          `FSR_OP_CLR_USER:   next_s.user_nvm[s.page[0]] = 1'b0;
          `FSR_OP_SET_SECURE: next_s.security = 1'b1;
          default:            next_s.security = s.security;
        endcase
      end else begin
        next_s.count = s.count - 16'h0001;
      end
    end

    // A new event in the cycle of the clearing read wins over the clear
    next_s.lock_viol = (s.lock_viol && !stat_read) || set_lockv;
    next_s.bad_cmd   = (s.bad_cmd && !stat_read) || set_bad;

    ev[`FSR_EV_IDLE]   = set_done;
    ev[`FSR_EV_LOCKV]  = set_lockv;
    ev[`FSR_EV_BADCMD] = set_bad;

    if (s.dp_valid && s.dp_write) begin
      if (s.dp_off == `FSR_OFF_IRQ_STAT) begin
        next_s.irq_status = s.irq_status & ~hwdata[2:0];
      end else if (s.dp_off == `FSR_OFF_IRQ_MASK) begin
        next_s.irq_mask = hwdata[2:0];
      end
    end
    next_s.irq_status = next_s.irq_status | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.dp_valid   <= 1'b0;
      s.dp_write   <= 1'b0;
      s.dp_off     <= `FSR_OFF_CMD;
      s.rdata      <= `FSR_RST_WORD;
      s.phase      <= FSR_READY;
      s.count      <= 16'h0000;
      s.op         <= `FSR_OP_NONE;
      s.page       <= 10'h000;
      s.locks      <= `FSR_RST_LOCKS;
      s.user_nvm   <= `FSR_RST_USER;
      s.security   <= 1'b0;
      s.lock_viol  <= 1'b0;
      s.bad_cmd    <= 1'b0;
      s.irq_status <= `FSR_RST_EV;
      s.irq_mask   <= `FSR_RST_EV;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

endmodule // fsr_top
`default_nettype wire

// ===== include/fsr_params.svh
// Constants for the flash status reporting block: register offsets,
// field positions, operation codes and reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

`define FSR_OFF_CMD        4'h0
`define FSR_OFF_STATUS     4'h4
`define FSR_OFF_IRQ_STAT   4'h8
`define FSR_OFF_IRQ_MASK   4'hC

`define FSR_KEY            8'h5A
`define FSR_KEY_HI         31
`define FSR_KEY_LO         24
`define FSR_PAGE_HI        17
`define FSR_PAGE_LO        8
`define FSR_OPC_HI         3
`define FSR_OPC_LO         0

`define FSR_OP_NONE        4'h0
`define FSR_OP_WRITE_PAGE  4'h1
`define FSR_OP_LOCK        4'h2
`define FSR_OP_WRITE_LOCK  4'h3
`define FSR_OP_UNLOCK      4'h4
`define FSR_OP_ERASE_ALL   4'h8
`define FSR_OP_SET_USER    4'hB
`define FSR_OP_CLR_USER    4'hD
`define FSR_OP_SET_SECURE  4'hF

`define FSR_BIT_IDLE       0
`define FSR_BIT_LOCKV      2
`define FSR_BIT_BADCMD     3
`define FSR_BIT_SECURE     4
`define FSR_USER_LO        8
`define FSR_USER_HI        9
`define FSR_LOCKS_LO       16
`define FSR_LOCKS_HI       31

`define FSR_EV_IDLE        0
`define FSR_EV_LOCKV       1
`define FSR_EV_BADCMD      2

`define FSR_RST_WORD       32'h0000_0000
`define FSR_RST_LOCKS      16'h0000
`define FSR_RST_USER       2'h0
`define FSR_RST_EV         3'h0

`endif

// ===== include/fsr_pkg.sv
// Types shared by the flash status reporting block.
// Field widths follow the constants header.
package fsr_pkg;

  typedef enum logic {
    FSR_READY,
    FSR_BUSY
  } fsr_phase_t;

  typedef struct packed {
    logic       dp_valid;
    logic       dp_write;
    logic [3:0] dp_off;
    logic [31:0] rdata;
    fsr_phase_t phase;
    logic [15:0] count;
    logic [3:0] op;
    logic [9:0] page;
    logic [15:0] locks;
    logic [1:0] user_nvm;
    logic       security;
    logic       lock_viol;
    logic       bad_cmd;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
  } fsr_state_t;

endpackage

// ===== test/fsr_assertions.sv
// Port checker for fsr_top, attached to every instance by the bind below.
// Assumes one AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module fsr_assertions #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              clk_en,
  // Bus
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk, lo, rd, rd_st, wr_cmd;
  assign tk     = hsel && hready && htrans[1] && clk_en;
  assign lo     = haddr[ADDR_W-1:4] == '0;
  assign rd     = tk && !hwrite;
  assign rd_st  = rd && lo && haddr[3:0] == 4'h4;
  assign wr_cmd = tk && hwrite && lo && haddr[3:0] == 4'h0;
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_ready_enable: assert property (hreadyout == clk_en) else $error("ready differs from enable");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property ((rd && !(lo && haddr[3:0] != 4'h0)) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_clears: assert property (rd_st ##1 rd_st ##1 rd_st |=> hrdata[3:2] == 2'h0)
    else $error("flags kept after read");
  a_bad_key: assert property (wr_cmd ##1 (clk_en && hwdata[31:24] != 8'h5A) ##1 rd_st |=> hrdata[3])
    else $error("bad key not flagged");
  a_busy_start: assert property (wr_cmd ##1 (clk_en && hwdata[31:24] == 8'h5A && hwdata[3:0] == 4'hF) ##1 rd_st
    |=> !hrdata[0])
    else $error("idle after command");
  a_mask_quiet: assert property ((tk && hwrite && lo && haddr[3:0] == 4'hC) ##1 (clk_en && hwdata[2:0] == 3'h0)
    |=> !irq) else $error("irq while masked");
  c_irq: cover property (irq);
  c_stall: cover property (!clk_en);
  c_burst: cover property (rd_st ##1 rd_st ##1 rd_st);
endmodule // fsr_assertions
bind fsr_top fsr_assertions #(.ADDR_W(ADDR_W)) u_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq);
`default_nettype wire

// ===== test/tb_fsr_top.sv
// Bench for fsr_top: AHB-Lite master tasks and a model of the status word.
// Assumes zero wait states while clk_en is high.
`timescale 1ns/1ps
`default_nettype none
module tb_fsr_top;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, irq, sec;
  logic [1:0]  htrans, user;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] locks;
  logic [7:0]  rnd;
  logic [3:0]  resv [7] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hE};
  int          n_mismatch, compares, i;
  assign hready = hreadyout;
  fsr_top #(.REGIONS(8), .BUSY_CYCLES(4)) uut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] st(logic idle, logic lv, logic bc);
    return {locks, 6'h00, user, 3'h0, sec, bc, lv, 1'b0, idle};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic cmd(logic [7:0] k, logic [3:0] op, logic [9:0] pg);
    xfer(1'b1, 32'h0, {k, 6'h00, pg, 4'h0, op});
  endtask
  task automatic stat(logic [31:0] e);
    xfer(1'b0, 32'h4, 32'h0);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic idle_wait;
    r = 32'h0;
    for (i = 0; i < 20 && r[0] !== 1'b1; i++) xfer(1'b0, 32'h4, 32'h0);
  endtask
  // Irq is combinational from registers, so look at it mid-cycle
  task automatic irq_is(logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask
  task results;
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    hresetn = 1'b0;
    {clk_en, hsel, hwrite, htrans} = 5'h18;
    {haddr, hwdata, locks, user, sec} = '0;
    rnd = 8'h47;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    stat(st(1'b1, 1'b0, 1'b0));
    cmd(8'h5A, 4'h2, {1'b0, rnd[2:0], rnd[7:2]});
    stat(st(1'b0, 1'b0, 1'b0));
    idle_wait();
    locks[rnd[2:0]] = 1'b1;
    stat(st(1'b1, 1'b0, 1'b0));
    cmd(8'h5A, 4'h3, {1'b0, rnd[2:0], 6'h3F});
    stat(st(1'b1, 1'b1, 1'b0));
    stat(st(1'b1, 1'b0, 1'b0));
    // Region 8 does not exist in the 8-region build
    cmd(8'h5A, 4'h2, 10'h200);
    idle_wait();
    stat(st(1'b1, 1'b0, 1'b0));
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      cmd(rnd == 8'h5A ? 8'hA5 : rnd, rnd[3:0], 10'h0);
      stat(st(1'b1, 1'b0, 1'b1));
    end
    foreach (resv[k]) begin
      cmd(8'h5A, resv[k], 10'h0);
      stat(st(1'b1, 1'b0, 1'b1));
    end
    cmd(8'h5A, 4'h0, 10'h0);
    stat(st(1'b1, 1'b0, 1'b0));
    cmd(8'hFF, 4'h1, 10'h0);
    haddr <= 32'h4;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    repeat (3) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    chk(hrdata, st(1'b1, 1'b0, 1'b0));
    for (int k = 0; k < 3; k++) begin
      cmd(8'h5A, k == 0 ? 4'hB : (k == 1 ? 4'hF : 4'hD), 10'h001);
      idle_wait();
      user[1] = k < 2;
      sec = k > 0;
      stat(st(1'b1, 1'b0, 1'b0));
    end
    // A frozen clock enable must also freeze the busy count
    cmd(8'h5A, 4'h2, 10'h1C0);
    clk_en <= 1'b0;
    repeat (8) @(posedge hclk);
    clk_en <= 1'b1;
    stat(st(1'b0, 1'b0, 1'b0));
    idle_wait();
    locks[7] = 1'b1;
    xfer(1'b1, 32'h4, 32'hFFFF_FFFF);
    stat(st(1'b1, 1'b0, 1'b0));
    xfer(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
    xfer(1'b1, 32'hC, 32'h7);
    irq_is(1'b1);
    xfer(1'b0, 32'hC, 32'h0);
    chk(r, 32'h7);
    xfer(1'b1, 32'h8, 32'h7);
    irq_is(1'b0);
    cmd(8'h00, 4'h0, 10'h0);
    irq_is(1'b1);
    xfer(1'b0, 32'h8, 32'h0);
    chk(r, 32'h4);
    xfer(1'b1, 32'hC, 32'h0);
    irq_is(1'b0);
    results();
  end
endmodule // tb_fsr_top
`default_nettype wire
